// File: logic/lcpc_div_if.sv
// Interface carrying one pulse divider's tick, code and toggle output.
// Assumes owner and divider run on the same clock.
`timescale 1ns/1ps
interface lcpc_div_if;
  import lcpc_pkg::*;
  logic tick;
  logic en;
  logic [DIV_W-1:0] divisor;
  logic out;
  modport owner (output tick, output en, output divisor, input out);
  modport divider (input tick, input en, input divisor, output out);
endinterface

// File: logic/lcpc_pkg.sv
// Package of the LCD cursor and panel configuration block.
// Assumes a 32-bit APB slave with one register per aligned word.
package lcpc_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CURSOR_X = 8'h00;
  localparam logic [7:0] OFF_CURSOR_Y = 8'h04;
  localparam logic [7:0] OFF_CURSOR_SIZE = 8'h08;
  localparam logic [7:0] OFF_BLINK = 8'h0C;
  localparam logic [7:0] OFF_PANEL_CFG = 8'h10;
  localparam logic [7:0] OFF_POLARITY = 8'h14;
  localparam logic [7:0] OFF_XDIR_RATE = 8'h18;
  localparam logic [7:0] OFF_SCREEN_W = 8'h1C;
  localparam logic [7:0] OFF_SCREEN_H = 8'h20;
  localparam logic [7:0] OFF_STATUS = 8'h24;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CX_FMT_LSB = 14;
  localparam int CX_COL_LSB = 0;
  localparam int CY_ROW_LSB = 0;
  localparam int CS_SPANX_LSB = 8;
  localparam int CS_SPANY_LSB = 0;
  localparam int BLK_ON_BIT = 7;
  localparam int BLK_DIV_LSB = 0;
  localparam int PC_BW_LSB = 2;
  localparam int PC_GS_LSB = 0;
  localparam int POL_CLK_BIT = 3;
  localparam int POL_FRM_BIT = 2;
  localparam int POL_LINE_BIT = 1;
  localparam int POL_PIX_BIT = 0;
  localparam int XR_SRC_BIT = 7;
  localparam int XR_RATE_LSB = 0;
  localparam int SW_LIM_LSB = 4;
  localparam int SH_LIM_LSB = 0;
  localparam int ST_COL_LSB = 0;
  localparam int ST_ROW_LSB = 16;
  localparam int ST_BLINK_BIT = 28;
  localparam int ST_XDIR_BIT = 29;

  // Divider code width shared by the blink and crystal counters.
  localparam int DIV_W = 7;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_CURSOR = 16'h0000;
  localparam logic [7:0] RST_CTRL8 = 8'h00;
  localparam logic [15:0] RST_SCREEN = 16'h0000;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FMT_TRANSPARENT = 2'b00,
    FMT_BLACK = 2'b01,
    FMT_REVERSE = 2'b10,
    FMT_WHITE = 2'b11
  } lcpc_fmt_t;

  typedef enum logic [1:0] {
    BW_1BIT = 2'b00,
    BW_2BIT = 2'b01,
    BW_4BIT = 2'b10,
    BW_8BIT = 2'b11
  } lcpc_bw_t;

endpackage

// File: logic/lcpc_pulse_div.sv
// Toggle divider: flips its output once every divisor+1 ticks.
// Assumes ticks are one-cycle pulses on pclk.
`timescale 1ns/1ps
module lcpc_pulse_div
  import lcpc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  lcpc_div_if.divider dv
);
  logic [DIV_W-1:0] cnt_reg;
  logic [DIV_W-1:0] cnt_next;
  logic out_reg;
  logic wrap;

  // The count wraps when it has seen divisor+1 ticks.
  assign wrap = dv.tick && (cnt_reg == dv.divisor);
  assign cnt_next = wrap ? '0 : cnt_reg + {{(DIV_W-1){1'b0}}, 1'b1};
  assign dv.out = out_reg;

  // Disabled means counter cleared and output parked low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
      out_reg <= 1'b0;
    end else if (!dv.en) begin
      cnt_reg <= '0;
      out_reg <= 1'b0;
    end else if (dv.tick) begin
      cnt_reg <= cnt_next;
      out_reg <= out_reg ^ wrap;
    end
  end

  // The output flips exactly in the cycle after a wrap.
  a_div_toggle: assert property (@(posedge pclk) disable iff (!presetn)
    dv.en ##1 dv.en |-> (dv.out != $past(dv.out)) == $past(wrap))
    else $error("divider output toggle not tied to wrap");
endmodule

// File: logic/lcpc_sync.sv
// Two-stage synchroniser, one chain per bit.
// Assumes inputs are asynchronous to pclk.
`timescale 1ns/1ps
module lcpc_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  // Each bit passes two flops; only the second is seen outside.
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic s1_reg;
    logic s2_reg;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        s1_reg <= 1'b0;
        s2_reg <= 1'b0;
      end else begin
        s1_reg <= async_in[i];
        s2_reg <= s1_reg;
      end
    end
    assign sync_out[i] = s2_reg;
  end
endmodule

// File: logic/lcpc_top.sv
// LCD cursor overlay, panel signal polarity and crystal direction.
// Assumes raw panel timing arrives from another clock domain,
// with pixel data stable around the raw shift clock's rising edge.
`timescale 1ns/1ps
module lcpc_top
  import lcpc_pkg::*;
#(
  parameter int LANES = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic raw_shift_clock,
  input wire logic raw_frame_marker,
  input wire logic raw_line_pulse,
  input wire logic [LANES-1:0] raw_pixel_data,
  output logic panel_shift_clock,
  output logic frame_marker,
  output logic line_pulse,
  output logic [LANES-1:0] panel_data,
  output logic crystal_direction_out,
  output logic [1:0] panel_bus_width,
  output logic [1:0] gray_level_mode
);

  // ----------------------------------------------------------------
  // Configuration storage
  // ----------------------------------------------------------------
  lcpc_fmt_t fmt_reg;
  logic [9:0] col_start_reg;
  logic [8:0] row_start_reg;
  logic [4:0] span_x_reg;
  logic [4:0] span_y_reg;
  logic blink_on_reg;
  logic [DIV_W-1:0] blink_div_reg;
  lcpc_bw_t bw_reg;
  logic [1:0] gray_reg;
  logic pol_clk_reg;
  logic pol_frm_reg;
  logic pol_line_reg;
  logic pol_pix_reg;
  logic xdir_src_reg;
  logic [DIV_W-1:0] xdir_rate_reg;
  logic [5:0] width_lim_reg;
  logic [8:0] height_lim_reg;
  logic [31:0] prdata_reg;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire wr_en = psel && penable && pwrite;
  wire rd_setup = psel && !penable && !pwrite;
  wire hit_cx = (paddr == OFF_CURSOR_X);
  wire hit_cy = (paddr == OFF_CURSOR_Y);
  wire hit_cs = (paddr == OFF_CURSOR_SIZE);
  wire hit_bk = (paddr == OFF_BLINK);
  wire hit_pc = (paddr == OFF_PANEL_CFG);
  wire hit_po = (paddr == OFF_POLARITY);
  wire hit_xr = (paddr == OFF_XDIR_RATE);
  wire hit_sw = (paddr == OFF_SCREEN_W);
  wire hit_sh = (paddr == OFF_SCREEN_H);
  wire hit_st = (paddr == OFF_STATUS);
  wire hit_any = hit_cx || hit_cy || hit_cs || hit_bk || hit_pc || hit_po
                 || hit_xr || hit_sw || hit_sh || hit_st;

  // Zero wait states; unmapped addresses answer with an error.
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_any;
  assign prdata = prdata_reg;
  assign panel_bus_width = bw_reg;
  assign gray_level_mode = gray_reg;

  // ----------------------------------------------------------------
  // Link side: synchronise and find edges
  // ----------------------------------------------------------------
  logic [LANES+2:0] link_s;
  logic clk_d_reg;
  logic frm_d_reg;
  logic line_d_reg;

  lcpc_sync #(
    .W(LANES + 3)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({raw_pixel_data, raw_line_pulse, raw_frame_marker, raw_shift_clock}),
    .sync_out(link_s)
  );

  wire clk_s = link_s[0];
  wire frm_s = link_s[1];
  wire line_s = link_s[2];
  wire [LANES-1:0] pix_s = link_s[LANES+2:3];
  wire shift_edge = clk_s && !clk_d_reg;
  wire frame_edge = frm_s && !frm_d_reg;
  wire line_edge = line_s && !line_d_reg;

  // ----------------------------------------------------------------
  // Dividers for blink and crystal direction
  // ----------------------------------------------------------------
  lcpc_div_if bdv ();
  lcpc_div_if xdv ();

  // Blink counts incoming frame pulses.
  assign bdv.tick = frame_edge;
  assign bdv.en = blink_on_reg;
  assign bdv.divisor = blink_div_reg;
  // Crystal counter source is frames or lines.
  wire xdir_tick = xdir_src_reg ? line_edge : frame_edge;
  assign xdv.tick = xdir_tick;
  assign xdv.en = 1'b1;
  assign xdv.divisor = xdir_rate_reg;
  assign crystal_direction_out = xdv.out;

  lcpc_pulse_div u_blink (
    .pclk(pclk),
    .presetn(presetn),
    .dv(bdv)
  );

  lcpc_pulse_div u_xdir (
    .pclk(pclk),
    .presetn(presetn),
    .dv(xdv)
  );

  // ----------------------------------------------------------------
  // Raster position
  // ----------------------------------------------------------------
  logic [10:0] col_reg;
  logic [9:0] row_reg;
  logic [3:0] lane_count;
  logic [LANES-1:0] lane_mask;

  // Pixels per shift clock follow the bus width code.
  assign lane_count = (bw_reg == BW_1BIT) ? 4'd1 :
                      (bw_reg == BW_2BIT) ? 4'd2 :
                      (bw_reg == BW_4BIT) ? 4'd4 : 4'd8;
  for (genvar i = 0; i < LANES; i++) begin : g_mask
    assign lane_mask[i] = (i < lane_count);
  end

  // Line resets the column, frame resets the row.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      col_reg <= '0;
      row_reg <= '0;
    end else begin
      if (line_edge) begin
        col_reg <= '0;
      end else if (shift_edge) begin
        col_reg <= col_reg + {7'h0, lane_count};
      end
      if (frame_edge) begin
        row_reg <= '0;
      end else if (line_edge) begin
        row_reg <= row_reg + 10'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Cursor window and overlay
  // ----------------------------------------------------------------
  wire [10:0] x_end = {1'b0, col_start_reg} + {6'h00, span_x_reg};
  wire [10:0] x_lim = {1'b0, width_lim_reg, 4'h0};
  wire [9:0] y_end = {1'b0, row_start_reg} + {5'h00, span_y_reg};
  wire row_in = (row_reg >= {1'b0, row_start_reg}) && (row_reg < y_end)
                && (row_reg <= {1'b0, height_lim_reg});
  // Blink phase high hides the cursor for that half period.
  wire cursor_shown = (fmt_reg != FMT_TRANSPARENT)
                      && !(blink_on_reg && bdv.out);
  logic [LANES-1:0] lane_hit;
  logic [LANES-1:0] lane_val;

  // Each lane is one pixel column of the current shift.
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    wire [10:0] col_i = col_reg + 11'(i);
    wire in_x = (col_i >= {1'b0, col_start_reg}) && (col_i < x_end)
                && (col_i < x_lim);
    wire cur_bit = (fmt_reg == FMT_BLACK) ? 1'b1 :
                   (fmt_reg == FMT_WHITE) ? 1'b0 : !pix_s[i];
    assign lane_hit[i] = in_x && row_in && cursor_shown;
    assign lane_val[i] = lane_mask[i]
                         && ((lane_hit[i] ? cur_bit : pix_s[i]) ^ pol_pix_reg);
  end

  // ----------------------------------------------------------------
  // Panel outputs
  // ----------------------------------------------------------------
  logic shift_out_reg;
  logic frm_out_reg;
  logic line_out_reg;
  logic [LANES-1:0] data_reg;

  // Outputs follow the delayed link level so data leads the clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_d_reg <= 1'b0;
      frm_d_reg <= 1'b0;
      line_d_reg <= 1'b0;
      shift_out_reg <= 1'b0;
      frm_out_reg <= 1'b0;
      line_out_reg <= 1'b0;
      data_reg <= '0;
    end else begin
      clk_d_reg <= clk_s;
      frm_d_reg <= frm_s;
      line_d_reg <= line_s;
      shift_out_reg <= clk_d_reg ^ !pol_clk_reg;
      frm_out_reg <= frm_d_reg ^ pol_frm_reg;
      line_out_reg <= line_d_reg ^ pol_line_reg;
      if (shift_edge) begin
        data_reg <= lane_val;
      end
    end
  end

  assign panel_shift_clock = shift_out_reg;
  assign frame_marker = frm_out_reg;
  assign line_pulse = line_out_reg;
  assign panel_data = data_reg;

  // ----------------------------------------------------------------
  // Register writes and reads
  // ----------------------------------------------------------------
  // Only defined fields are stored; reserved bits read as zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fmt_reg <= lcpc_fmt_t'(RST_CURSOR[CX_FMT_LSB +: 2]);
      col_start_reg <= RST_CURSOR[9:0];
      row_start_reg <= RST_CURSOR[8:0];
      span_x_reg <= RST_CURSOR[4:0];
      span_y_reg <= RST_CURSOR[4:0];
      blink_on_reg <= RST_CTRL8[BLK_ON_BIT];
      blink_div_reg <= RST_CTRL8[DIV_W-1:0];
      bw_reg <= lcpc_bw_t'(RST_CTRL8[PC_BW_LSB +: 2]);
      gray_reg <= RST_CTRL8[1:0];
      {pol_clk_reg, pol_frm_reg, pol_line_reg, pol_pix_reg} <= RST_CTRL8[3:0];
      xdir_src_reg <= RST_CTRL8[XR_SRC_BIT];
      xdir_rate_reg <= RST_CTRL8[DIV_W-1:0];
      width_lim_reg <= RST_SCREEN[5:0];
      height_lim_reg <= RST_SCREEN[8:0];
    end else if (wr_en) begin
      if (hit_cx) begin
        fmt_reg <= lcpc_fmt_t'(pwdata[CX_FMT_LSB +: 2]);
        col_start_reg <= pwdata[CX_COL_LSB +: 10];
      end
      if (hit_cy) begin
        row_start_reg <= pwdata[CY_ROW_LSB +: 9];
      end
      if (hit_cs) begin
        span_x_reg <= pwdata[CS_SPANX_LSB +: 5];
        span_y_reg <= pwdata[CS_SPANY_LSB +: 5];
      end
      if (hit_bk) begin
        blink_on_reg <= pwdata[BLK_ON_BIT];
        blink_div_reg <= pwdata[BLK_DIV_LSB +: DIV_W];
      end
      if (hit_pc) begin
        bw_reg <= lcpc_bw_t'(pwdata[PC_BW_LSB +: 2]);
        gray_reg <= pwdata[PC_GS_LSB +: 2];
      end
      if (hit_po) begin
        pol_clk_reg <= pwdata[POL_CLK_BIT];
        pol_frm_reg <= pwdata[POL_FRM_BIT];
        pol_line_reg <= pwdata[POL_LINE_BIT];
        pol_pix_reg <= pwdata[POL_PIX_BIT];
      end
      if (hit_xr) begin
        xdir_src_reg <= pwdata[XR_SRC_BIT];
        xdir_rate_reg <= pwdata[XR_RATE_LSB +: DIV_W];
      end
      if (hit_sw) begin
        width_lim_reg <= pwdata[SW_LIM_LSB +: 6];
      end
      if (hit_sh) begin
        height_lim_reg <= pwdata[SH_LIM_LSB +: 9];
      end
    end
  end

  // Read words are assembled from stored fields and live state.
  wire [31:0] rd_cx = {16'h0000, fmt_reg, 4'h0, col_start_reg};
  wire [31:0] rd_cy = {23'h00_0000, row_start_reg};
  wire [31:0] rd_cs = {19'h0_0000, span_x_reg, 3'h0, span_y_reg};
  wire [31:0] rd_bk = {24'h00_0000, blink_on_reg, blink_div_reg};
  wire [31:0] rd_pc = {28'h000_0000, bw_reg, gray_reg};
  wire [31:0] rd_po = {28'h000_0000, pol_clk_reg, pol_frm_reg, pol_line_reg,
                       pol_pix_reg};
  wire [31:0] rd_xr = {24'h00_0000, xdir_src_reg, xdir_rate_reg};
  wire [31:0] rd_sw = {22'h00_0000, width_lim_reg, 4'h0};
  wire [31:0] rd_sh = {23'h00_0000, height_lim_reg};
  wire [31:0] rd_st = {2'h0, xdv.out, bdv.out, 2'h0, row_reg, 5'h00, col_reg};
  wire [31:0] rd_word = hit_cx ? rd_cx : hit_cy ? rd_cy : hit_cs ? rd_cs :
                        hit_bk ? rd_bk : hit_pc ? rd_pc : hit_po ? rd_po :
                        hit_xr ? rd_xr : hit_sw ? rd_sw : hit_sh ? rd_sh :
                        hit_st ? rd_st : 32'h0000_0000;

  // Read data is captured in the setup cycle and held for access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_reg <= rd_word;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_shift_edge_pol: assert property (
    shift_edge ##1 $stable(pol_clk_reg) |->
    ##1 (panel_shift_clock == pol_clk_reg) && !$stable(panel_shift_clock))
    else $error("shift clock active edge has wrong sense");

  a_frame_pol: assert property (
    $rose(frm_d_reg) |=> frame_marker == !$past(pol_frm_reg))
    else $error("frame marker has wrong active level");

  a_line_pol: assert property (
    $rose(line_d_reg) |=> line_pulse == !$past(pol_line_reg))
    else $error("line pulse has wrong active level");

  a_pix_pass: assert property (
    shift_edge && lane_mask[0] && !lane_hit[0] |=>
    panel_data[0] == ($past(pix_s[0]) ^ $past(pol_pix_reg)))
    else $error("uncovered pixel not passed with its polarity");

  a_cursor_black: assert property (
    shift_edge && lane_hit[0] && fmt_reg == FMT_BLACK && !pol_pix_reg |=>
    panel_data[0])
    else $error("black cursor pixel not driven dark");

  a_lane_width: assert property (
    shift_edge && bw_reg == BW_1BIT |=> panel_data[LANES-1:1] == '0)
    else $error("lanes above bus width are not zero");

  a_cursor_in_x: assert property (
    lane_hit[0] |-> col_reg >= {1'b0, col_start_reg} && col_reg < x_end
    && col_reg < x_lim)
    else $error("cursor outside its columns");

  a_cursor_in_y: assert property (
    lane_hit[0] |-> row_reg < y_end && row_reg <= {1'b0, height_lim_reg})
    else $error("cursor outside its rows");

  a_blink_steady: assert property (
    !blink_on_reg ##1 !blink_on_reg |-> !bdv.out)
    else $error("cursor blink phase moved while steady");

  a_blink_hides: assert property (
    blink_on_reg && bdv.out |-> lane_hit == '0)
    else $error("cursor shown in hidden blink phase");

  a_xdir_source: assert property (
    !xdir_tick |=> $stable(crystal_direction_out))
    else $error("crystal direction moved without a source pulse");

endmodule

// File: testbench/lcd_cursor_panel_config_tb.sv
// Testbench of the LCD cursor overlay and panel configuration block.
// Assumes lcpc_top with eight lanes and the panel model on its raw side.
`timescale 1ns/1ps
module lcd_cursor_panel_config_tb;
  import lcpc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
  logic rsc, rfm, rlp, psc, fm, lp, xd;
  logic [7:0] paddr, rpd, pd, bad [2] = '{8'h28, 8'h01};
  logic [31:0] pwdata, prdata, q;
  logic [1:0] bw, gs;
  logic [31:0] rw_mask [9] = '{32'h0000_C3FF, 32'h0000_01FF, 32'h0000_1F1F,
    32'h0000_00FF, 32'h0000_000F, 32'h0000_000F, 32'h0000_00FF, 32'h0000_03F0,
    32'h0000_01FF};
  int n_mismatch = 0;
  int checks = 0;

  lcpc_top #(.LANES(8)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .raw_shift_clock(rsc),
    .raw_frame_marker(rfm), .raw_line_pulse(rlp), .raw_pixel_data(rpd),
    .panel_shift_clock(psc), .frame_marker(fm), .line_pulse(lp),
    .panel_data(pd), .crystal_direction_out(xd), .panel_bus_width(bw),
    .gray_level_mode(gs));
  lcpc_panel_model #(.LANES(8)) model (.raw_shift_clock(rsc),
    .raw_frame_marker(rfm), .raw_line_pulse(rlp), .raw_pixel_data(rpd));

  // ------------------------------------------------------------
  // Clock, watchdog and shared tasks
  // ------------------------------------------------------------
  // The 40 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // The watchdog cuts a hang short.
  initial begin
    #400_000;
    n_mismatch++;
    stop_test();
  end
  task automatic stop_test();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer; read data and error are taken at the pready edge.
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0000_0000);
    chk("prdata", e, q);
    // Only the mapped aligned words answer without an error.
    chk("pslverr_rd", 32'(a > OFF_STATUS || a[1:0] != 2'b00), 32'(se));
  endtask
  task automatic reset_dut();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  // Expected lanes 0 to 7 of the shift that holds the cursor columns.
  function automatic logic [7:0] cexp(input logic [1:0] f, input logic p);
    logic [3:0] nib;
    nib = (f == 2'b01) ? 4'hF : (f == 2'b10) ? 4'hA : (f == 2'b11) ? 4'h0 : 4'h5;
    return {4'hA, nib} ^ {8{p}};
  endfunction
  // One line of two shifts: columns 0 to 7, then 8 to 15 on the eight-lane bus.
  task automatic line(input logic f, input logic [7:0] e1, input logic [7:0] e2);
    model.line_start(f);
    model.shift(8'hA5);
    chk("panel_data_a", 32'(e1), 32'(pd));
    model.shift(8'hA5);
    chk("panel_data_b", 32'(e2), 32'(pd));
  endtask
  // Waits for a toggle, then expects the next one exactly n pulses later.
  task automatic xdir(input logic s, input int n);
    logic v;
    int k;
    apb(OFF_XDIR_RATE, 1'b1, 32'((s << 7) | (n - 1)));
    v = xd;
    k = 0;
    while (xd === v && k < 130) begin
      model.line_start(!s);
      k++;
    end
    chk("crystal_wait", 32'h0000_0000, 32'(xd === v));
    v = xd;
    for (int j = 1; j <= n; j++) begin
      // With frames selected, a line without a frame must not count.
      if (!s) begin
        model.line_start(1'b0);
      end
      model.line_start(!s);
      chk("crystal_out", 32'(j == n ? !v : v), 32'(xd));
    end
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  // The main sequence.
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    reset_dut();
    for (int i = 0; i < 10; i++) begin
      rd(8'(4 * i), 32'h0000_0000);
    end
    for (int i = 0; i < 9; i++) begin
      apb(8'(4 * i), 1'b1, rw_mask[i]);
      rd(8'(4 * i), rw_mask[i]);
    end
    foreach (bad[i]) begin
      rd(bad[i], 32'h0000_0000);
      chk("pslverr", 32'h0000_0001, 32'(se));
    end
    reset_dut();
    rd(OFF_CURSOR_X, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      apb(OFF_PANEL_CFG, 1'b1, 32'(i * 4 + i % 3));
      chk("bus_width", 32'(i), 32'(bw));
      chk("gray_mode", 32'(i % 3), 32'(gs));
    end
    for (int p = 0; p < 16; p++) begin
      apb(OFF_POLARITY, 1'b1, 32'(p));
      repeat (8) @(negedge pclk);
      chk("shift_clock", 32'(!p[3]), 32'(psc));
      chk("frame_marker", 32'(p[2]), 32'(fm));
      chk("line_pulse", 32'(p[1]), 32'(lp));
    end
    xdir(1'b0, 3);
    xdir(1'b1, 2);
    xdir(1'b1, 128);
    apb(OFF_PANEL_CFG, 1'b1, 32'h0000_000C);
    apb(OFF_SCREEN_W, 1'b1, 32'h0000_0010);
    apb(OFF_CURSOR_SIZE, 1'b1, 32'h0000_0401);
    for (int k = 0; k < 8; k++) begin
      apb(OFF_POLARITY, 1'b1, 32'(k / 4));
      apb(OFF_CURSOR_X, 1'b1, 32'(((k % 4) << 14) | 8));
      line(1'b1, 8'hA5 ^ {8{k[2]}}, cexp(2'(k % 4), k[2]));
    end
    apb(OFF_POLARITY, 1'b1, 32'h0000_0000);
    apb(OFF_CURSOR_X, 1'b1, 32'h0000_4008);
    apb(OFF_SCREEN_H, 1'b1, 32'h0000_0001);
    apb(OFF_CURSOR_Y, 1'b1, 32'h0000_0001);
    line(1'b1, 8'hA5, 8'hA5);
    line(1'b0, 8'hA5, 8'hAF);
    line(1'b0, 8'hA5, 8'hA5);
    apb(OFF_SCREEN_W, 1'b1, 32'h0000_0000);
    apb(OFF_CURSOR_Y, 1'b1, 32'h0000_0000);
    line(1'b1, 8'hA5, 8'hA5);
    apb(OFF_SCREEN_W, 1'b1, 32'h0000_0010);
    line(1'b1, 8'hA5, 8'hAF);
    // One-lane bus: one column per shift, white cursor from column 1.
    apb(OFF_PANEL_CFG, 1'b1, 32'h0000_0000);
    apb(OFF_CURSOR_X, 1'b1, 32'h0000_C001);
    line(1'b1, 8'h01, 8'h00);
    apb(OFF_PANEL_CFG, 1'b1, 32'h0000_000C);
    apb(OFF_CURSOR_X, 1'b1, 32'h0000_4008);
    apb(OFF_BLINK, 1'b1, 32'h0000_0081);
    for (int k = 0; k < 4; k++) begin
      line(1'b1, 8'hA5, (k == 1 || k == 2) ? 8'hA5 : 8'hAF);
    end
    stop_test();
  end
endmodule

// File: testbench/lcpc_panel_model.sv
// Panel-side model that makes the raw shift clock, line, frame and lanes.
// Assumes a 200 ns shift period; the link stands still between lines.
`timescale 1ns/1ps
module lcpc_panel_model #(
  parameter int LANES = 8
) (
  output logic raw_shift_clock,
  output logic raw_frame_marker,
  output logic raw_line_pulse,
  output logic [LANES-1:0] raw_pixel_data
);
  // Idle levels at time zero.
  initial begin
    raw_shift_clock = 1'b0;
    raw_frame_marker = 1'b0;
    raw_line_pulse = 1'b0;
    raw_pixel_data = '0;
  end
  // One line start, with a frame start too when f is set.
  task automatic line_start(input logic f);
    #7;
    raw_line_pulse = 1'b1;
    raw_frame_marker = f;
    #200;
    raw_line_pulse = 1'b0;
    raw_frame_marker = 1'b0;
    #200;
  endtask
  // One shift; after the falling edge the lanes turn to the inverse.
  task automatic shift(input logic [LANES-1:0] d);
    raw_pixel_data = d;
    #50;
    raw_shift_clock = 1'b1;
    #100;
    raw_shift_clock = 1'b0;
    raw_pixel_data = ~d;
    #50;
  endtask
endmodule
